/* dv/mac_phy_interface_mapper_tb.sv */
// Purpose: Self-checking bench for the pin mapper in all five modes at once.
// Assumes: Outputs settle well inside the sixteen cycles waited per symbol.
// Notes: Serial instances see collision held low by the bench.
`timescale 1ns/1ps
`default_nettype none
module mac_phy_interface_mapper_tb;
	import phy_map_pkg::*;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	tx_word_t mac_tx = '0;
	logic f_en = 1'b0, f_er = 1'b0, gig = 1'b0, go = 1'b0;
	logic [3:0] f_nib = 4'h0;
	logic s_v = 1'b0, s_e = 1'b0, s_c = 1'b0, s_s = 1'b0;
	logic [7:0] s_d = 8'h00;
	logic p_clk, p_v, p_e, p_c, p_s;
	logic [7:0] p_d;
	logic o_en[5], o_er[5], o_ls[5], o_fdv[5], o_al[5], o_col[5], o_crs[5];
	logic o_rise[5];
	int rises[5] = '{default: 0};
	logic [7:0] o_d[5];
	logic [3:0] o_fn[5];
	rx_word_t o_rx[5];
	int failures = 0, num_checks = 0;
	logic [31:0] seed = 32'h00002D02;
	logic [31:0] r;
	// Far side of the pins
	phy_rx_model phy_rx_model_inst (.go(go), .src({s_v, s_e, s_d, s_c, s_s}),
		.rx_clk(p_clk), .rx_valid(p_v), .rx_error(p_e), .rx_data(p_d),
		.col(p_c), .crs(p_s));
	// One mapper per static mode, all fed the same stimulus except collision, held low for the serial modes
	for (genvar g = 0; g < 5; g++) begin : gen_mode
		mac_phy_interface_mapper #(.MODE(phy_mode_t'(g))) mac_phy_interface_mapper_inst (
			.ref_clk(ref_clk), .reset(reset), .mac_tx(mac_tx), .tx_falling_en(f_en),
			.tx_falling_er(f_er), .tx_falling_nib(f_nib), .link_is_gig(gig),
			.phy_rx_valid_in(p_v), .phy_rx_error_in(p_e), .phy_rx_data_in(p_d),
			.phy_collision_in(p_c & (g < 3)),
			.phy_carrier_sense_in(p_s), .phy_rx_clk(p_clk),
			.phy_tx_enable_out(o_en[g]), .phy_tx_error_out(o_er[g]),
			.phy_tx_data_out(o_d[g]), .low_speed_indicator(o_ls[g]), .mac_rx(o_rx[g]),
			.rx_falling_dv(o_fdv[g]), .rx_falling_nib(o_fn[g]),
			.transceiver_comma_realign(o_al[g]), .mac_collision(o_col[g]),
			.mac_carrier_sense(o_crs[g]), .rx_clk_rise(o_rise[g]));
	end
	// 200 MHz clock
	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end
	// Repeatable xorshift source
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	// Compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Expected transmit data pins for one mode
	function automatic logic [15:0] exp_txd(input int g);
		if (g == 0) return 16'({4'h0, mac_tx.data[3:0]});
		if (g == 2) return 16'({f_nib, mac_tx.data[3:0]});
		return 16'(mac_tx.data);
	endfunction : exp_txd
	// Expected pin and core values for one mode
	task automatic check_mode(input int g);
		chk(16'(o_d[g]), exp_txd(g));
		chk(16'(o_ls[g]), 16'((g == 0) | !gig));
		chk(16'(o_col[g]), 16'((g == 0) & s_c));
		chk(16'(o_crs[g]), 16'((g == 0) & s_s));
		if (g < 3) begin
			chk(16'(o_en[g]), 16'(mac_tx.en));
			chk(16'(o_er[g]), 16'((g == 2) ? f_en ^ f_er : mac_tx.er));
			chk(16'(o_rx[g].data[3:0]), 16'(s_d[3:0]));
			chk(16'(o_rx[g].dv), 16'(s_v));
			chk(16'(o_rx[g].er), 16'((g < 2) & s_e));
		end
		if (g == 0) chk(16'(o_rx[g].data), 16'({4'h0, s_d[3:0]}));
		if (g == 1) chk(16'(o_rx[g].data), 16'(s_d));
		if (g == 2) chk(16'({o_fdv[g], o_fn[g]}), 16'({s_e, s_d[7:4]}));
		if (g > 2) chk(16'({o_al[g], o_rx[g].dv, o_rx[g].data}), 16'({s_v, 1'b0, s_d}));
	endtask : check_mode
	// Count link clock rising edges seen by each instance; one per symbol
	always @(posedge ref_clk) begin
		for (int g = 0; g < 5; g++) begin
			if (o_rise[g]) rises[g]++;
		end
	end
	// Counts and verdict
	task automatic summarize();
		$display("checks=%0d failures=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize
	// Main sequence: all-ones and all-zeros corners, then random symbols
	initial begin
		repeat (6) @(posedge ref_clk);
		for (int g = 0; g < 5; g++) chk(16'({o_en[g], o_er[g], o_d[g]}), 16'h0000);
		reset <= 1'b0;
		for (int i = 0; i < 40; i++) begin
			@(posedge ref_clk);
			r = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h00000000 : xs();
			{mac_tx, f_en, f_er, f_nib, gig} <= r[16:0];
			{s_v, s_e, s_d, s_c, s_s} <= r[28:17];
			go <= 1'b1;
			repeat (16) @(posedge ref_clk);
			for (int g = 0; g < 5; g++) check_mode(g);
			for (int g = 0; g < 5; g++) chk(16'(rises[g]), 16'(i + 1));
			go <= 1'b0;
			$display("test %0d done", i);
		end
		summarize();
	end
	// Hang guard, far beyond the expected few microseconds
	initial begin
		#20000;
		failures++;
		summarize();
	end
endmodule : mac_phy_interface_mapper_tb
`default_nettype wire

/* dv/phy_rx_model.sv */
// Purpose: Behavioural PHY or transceiver receive side for the pin mapper bench.
// Assumes: One symbol per request; the link clock stands low between symbols.
// Notes: The pins change half a link period before the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module phy_rx_model (
	input wire logic go,
	input wire logic [11:0] src,
	output logic rx_clk,
	output logic rx_valid,
	output logic rx_error,
	output logic [7:0] rx_data,
	output logic col,
	output logic crs
);
	// Quiet pins and a still clock at start
	initial begin
		rx_clk = 1'b0;
		{rx_valid, rx_error, rx_data, col, crs} = 12'h000;
	end
	// One symbol, 48 ns link period, centred on the rising edge
	always @(posedge go) begin
		{rx_valid, rx_error, rx_data, col, crs} <= src;
		#24 rx_clk = 1'b1;
		#24 rx_clk = 1'b0;
	end
	// Released data lines stop showing the last value
	always @(negedge go) begin
		rx_data <= ~rx_data;
	end
endmodule : phy_rx_model
`default_nettype wire

/* src/mac_phy_interface_mapper.sv */
// Purpose: Map generic MAC transmit/receive words onto MII, GMII, RGMII or serial pins.
// Assumes: Mode strapped by parameter; pin inputs are resynchronised by two flops.
// Notes: RGMII rising/falling pairs are presented for external DDR cells.
`timescale 1ns/1ps
`default_nettype none
module mac_phy_interface_mapper #(
	parameter phy_map_pkg::phy_mode_t MODE = phy_map_pkg::MODE_GMII
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire phy_map_pkg::tx_word_t mac_tx,
	input wire logic tx_falling_en,
	input wire logic tx_falling_er,
	input wire logic [3:0] tx_falling_nib,
	input wire logic link_is_gig,
	input wire logic phy_rx_valid_in,
	input wire logic phy_rx_error_in,
	input wire logic [7:0] phy_rx_data_in,
	input wire logic phy_collision_in,
	input wire logic phy_carrier_sense_in,
	input wire logic phy_rx_clk,
	output logic phy_tx_enable_out,
	output logic phy_tx_error_out,
	output logic [7:0] phy_tx_data_out,
	output logic low_speed_indicator,
	output phy_map_pkg::rx_word_t mac_rx,
	output logic rx_falling_dv,
	output logic [3:0] rx_falling_nib,
	output logic transceiver_comma_realign,
	output logic mac_collision,
	output logic mac_carrier_sense,
	output logic rx_clk_rise
);
	import phy_map_pkg::*;

	// Mode decode used in more than one place
	function automatic logic is_serial(input phy_mode_t m);
		is_serial = (m == MODE_SGMII) || (m == MODE_BASEX);
	endfunction : is_serial

	// Static mode: a parameter, so it cannot move while running
	localparam phy_mode_t MODE_C = MODE;

	// Two-stage synchronisers for everything from the pins
	logic [11:0] pin_s1_q, pin_s1_d;
	logic [11:0] pin_s2_q, pin_s2_d;
	logic rxclk_s3_q, rxclk_s3_d; // Third stage only for edge finding

	// Synchroniser next values
	always_comb begin
		pin_s1_d = {phy_rx_clk, phy_carrier_sense_in, phy_collision_in,
			phy_rx_error_in, phy_rx_valid_in, phy_rx_data_in[6:0]};
		pin_s2_d = pin_s1_q;
		rxclk_s3_d = pin_s2_q[11];
	end

	// Synchroniser registers; stage 2, and the clock's stage 3 for edge finding, are read by logic
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			rxclk_s3_q <= 1'b0;
		end else begin
			pin_s1_q <= pin_s1_d;
			pin_s2_q <= pin_s2_d;
			rxclk_s3_q <= rxclk_s3_d;
		end
	end

	// Bit 7 of rx data rides its own pair to keep the bundle width tidy
	logic rxd7_s1_q, rxd7_s2_q;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rxd7_s1_q <= 1'b0;
			rxd7_s2_q <= 1'b0;
		end else begin
			rxd7_s1_q <= phy_rx_data_in[7];
			rxd7_s2_q <= rxd7_s1_q;
		end
	end

	// Named views of synchronised pins
	logic [7:0] rxd_s;
	logic rxdv_s, rxer_s, col_s, crs_s, rxclk_s;
	always_comb begin
		rxd_s = {rxd7_s2_q, pin_s2_q[6:0]};
		rxdv_s = pin_s2_q[7];
		rxer_s = pin_s2_q[8];
		col_s = pin_s2_q[9];
		crs_s = pin_s2_q[10];
		rxclk_s = pin_s2_q[11];
	end

	// Transmit output registers
	logic tx_en_q, tx_en_d, tx_er_q, tx_er_d;
	logic [7:0] tx_data_q, tx_data_d;
	logic speed_q, speed_d;

	// Transmit mapping by mode
	always_comb begin
		tx_en_d = mac_tx.en;
		tx_er_d = mac_tx.er;
		tx_data_d = mac_tx.data;
		unique case (MODE_C)
			MODE_MII: begin
				// Upper nibble forced low
				tx_data_d = {NIB_ZERO, mac_tx.data[LO_NIB_LSB +: NIB_W]};
			end
			MODE_GMII: begin
				// Full byte with enable and error as is
				tx_data_d = mac_tx.data;
			end
			MODE_RGMII: begin
				// Ctl rising on enable, falling on falling enable XOR error
				tx_en_d = mac_tx.en;
				tx_er_d = tx_falling_en ^ tx_falling_er;
				// Rising nibble low, falling nibble high; pins feed DDR cells
				tx_data_d = {tx_falling_nib, mac_tx.data[LO_NIB_LSB +: NIB_W]};
			end
			MODE_SGMII, MODE_BASEX: begin
				// Whole byte toward the transceiver
				tx_data_d = mac_tx.data;
			end
			default: begin
				tx_data_d = BYTE_ZERO;
			end
		endcase
		// Low-speed flag: serial/GMII at 1G run low unless the link says otherwise
		speed_d = (MODE_C == MODE_MII) || !link_is_gig;
	end

	// Transmit registers
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tx_en_q <= 1'b0;
			tx_er_q <= 1'b0;
			tx_data_q <= BYTE_ZERO;
			speed_q <= 1'b0;
		end else begin
			tx_en_q <= tx_en_d;
			tx_er_q <= tx_er_d;
			tx_data_q <= tx_data_d;
			speed_q <= speed_d;
		end
	end

	// Receive registers
	rx_word_t rx_q, rx_d;
	logic rx_fdv_q, rx_fdv_d;
	logic [3:0] rx_fnib_q, rx_fnib_d;
	logic realign_q, realign_d;
	logic col_q, col_d, crs_q, crs_d;
	logic rclk_rise_q, rclk_rise_d;

	// Receive mapping by mode
	always_comb begin
		rx_d.dv = rxdv_s;
		rx_d.er = rxer_s;
		rx_d.data = rxd_s;
		rx_fdv_d = 1'b0;
		rx_fnib_d = NIB_ZERO;
		realign_d = 1'b0;
		col_d = 1'b0;
		crs_d = 1'b0;
		rclk_rise_d = rxclk_s && !rxclk_s3_q;
		unique case (MODE_C)
			MODE_MII: begin
				// Upper nibble is unconnected and ignored
				rx_d.data = {NIB_ZERO, rxd_s[LO_NIB_LSB +: NIB_W]};
				col_d = col_s;
				crs_d = crs_s;
			end
			MODE_GMII: begin
				rx_d.data = rxd_s;
			end
			MODE_RGMII: begin
				// Split into rising and falling halves for DDR capture
				rx_d.data = {NIB_ZERO, rxd_s[LO_NIB_LSB +: NIB_W]};
				rx_fnib_d = rxd_s[HI_NIB_LSB +: NIB_W];
				rx_d.dv = rxdv_s;
				rx_d.er = 1'b0;
				rx_fdv_d = rxer_s;
			end
			MODE_SGMII, MODE_BASEX: begin
				// Valid pin is the realign flag, not a qualifier
				rx_d.data = rxd_s;
				rx_d.dv = 1'b0;
				realign_d = rxdv_s;
				// Collision pin ignored; outside logic ties it low
				col_d = 1'b0;
			end
			default: begin
				rx_d.data = BYTE_ZERO;
			end
		endcase
	end

	// Receive register bank
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rx_q <= '0;
			rx_fdv_q <= 1'b0;
			rx_fnib_q <= NIB_ZERO;
			realign_q <= 1'b0;
			col_q <= 1'b0;
			crs_q <= 1'b0;
			rclk_rise_q <= 1'b0;
		end else begin
			rx_q <= rx_d;
			rx_fdv_q <= rx_fdv_d;
			rx_fnib_q <= rx_fnib_d;
			realign_q <= realign_d;
			col_q <= col_d;
			crs_q <= crs_d;
			rclk_rise_q <= rclk_rise_d;
		end
	end

	// Outputs straight from flops
	assign phy_tx_enable_out = tx_en_q;
	assign phy_tx_error_out = tx_er_q;
	assign phy_tx_data_out = tx_data_q;
	assign low_speed_indicator = speed_q;
	assign mac_rx = rx_q;
	assign rx_falling_dv = rx_fdv_q;
	assign rx_falling_nib = rx_fnib_q;
	assign transceiver_comma_realign = realign_q;
	assign mac_collision = col_q;
	assign mac_carrier_sense = crs_q;
	assign rx_clk_rise = rclk_rise_q;

	// Checks next to the logic
	sequence s_mii_tx;
		MODE_C == MODE_MII;
	endsequence

	a_mii_upper_low: assert property (@(posedge ref_clk) disable iff (reset)
		s_mii_tx |=> phy_tx_data_out[7:4] == NIB_ZERO)
		else $error("MII upper transmit nibble not low");
	a_mii_tx_low: assert property (@(posedge ref_clk) disable iff (reset)
		s_mii_tx |=> phy_tx_data_out[3:0] == $past(mac_tx.data[3:0]))
		else $error("MII transmit nibble mismatch");
	a_gmii_byte_map: assert property (@(posedge ref_clk) disable iff (reset)
		(MODE_C == MODE_GMII) |=> phy_tx_data_out == $past(mac_tx.data)
		&& phy_tx_enable_out == $past(mac_tx.en) && phy_tx_error_out == $past(mac_tx.er))
		else $error("GMII transmit mapping wrong");
	a_rgmii_ctl_split: assert property (@(posedge ref_clk) disable iff (reset)
		(MODE_C == MODE_RGMII) |=> phy_tx_error_out == $past(tx_falling_en ^ tx_falling_er))
		else $error("RGMII falling ctl wrong");
	a_rgmii_tx_nib: assert property (@(posedge ref_clk) disable iff (reset)
		(MODE_C == MODE_RGMII) |=> phy_tx_data_out[7:4] == $past(tx_falling_nib))
		else $error("RGMII falling nibble misplaced");
	a_rgmii_rx_nib: assert property (@(posedge ref_clk) disable iff (reset)
		(MODE_C == MODE_RGMII) |-> ##3 rx_falling_nib == $past(phy_rx_data_in[7:4], 3))
		else $error("RGMII receive falling nibble wrong");
	a_mii_rx_upper: assert property (@(posedge ref_clk) disable iff (reset)
		(MODE_C == MODE_MII) |-> mac_rx.data[7:4] == NIB_ZERO)
		else $error("MII receive upper nibble leaked");
	a_serial_realign: assert property (@(posedge ref_clk) disable iff (reset)
		is_serial(MODE_C) |-> ##3 transceiver_comma_realign == $past(phy_rx_valid_in, 3)
		&& !mac_rx.dv)
		else $error("Serial realign mapping wrong");
	a_mii_col_path: assert property (@(posedge ref_clk) disable iff (reset)
		(MODE_C == MODE_MII) |-> ##3 mac_collision == $past(phy_collision_in, 3))
		else $error("MII collision not forwarded");
	a_speed_flag: assert property (@(posedge ref_clk) disable iff (reset)
		!link_is_gig |=> low_speed_indicator)
		else $error("Speed indicator not high at low speed");

	// Mode predicates shared by the remaining checks
	sequence s_rgmii_on;
		MODE_C == MODE_RGMII;
	endsequence
	sequence s_serial_on;
		is_serial(MODE_C);
	endsequence

	a_rgmii_tx_en: assert property (@(posedge ref_clk) disable iff (reset)
		s_rgmii_on |=> phy_tx_enable_out == $past(mac_tx.en))
		else $error("RGMII rising ctl wrong");
	a_rgmii_tx_low: assert property (@(posedge ref_clk) disable iff (reset)
		s_rgmii_on |=> phy_tx_data_out[3:0] == $past(mac_tx.data[3:0]))
		else $error("RGMII rising nibble misplaced");
	a_rgmii_rx_ctl: assert property (@(posedge ref_clk) disable iff (reset)
		s_rgmii_on |-> ##3 mac_rx.dv == $past(phy_rx_valid_in, 3)
		&& rx_falling_dv == $past(phy_rx_error_in, 3) && !mac_rx.er)
		else $error("RGMII receive ctl split wrong");
	a_rgmii_rx_low: assert property (@(posedge ref_clk) disable iff (reset)
		s_rgmii_on |-> ##3 mac_rx.data[3:0] == $past(phy_rx_data_in[3:0], 3))
		else $error("RGMII receive rising nibble wrong");
	a_serial_tx_byte: assert property (@(posedge ref_clk) disable iff (reset)
		s_serial_on |=> phy_tx_data_out == $past(mac_tx.data))
		else $error("Serial transmit byte wrong");
	a_serial_rx_byte: assert property (@(posedge ref_clk) disable iff (reset)
		s_serial_on |-> ##3 mac_rx.data == $past(phy_rx_data_in, 3))
		else $error("Serial receive byte wrong");
	a_serial_col_quiet: assert property (@(posedge ref_clk) disable iff (reset)
		s_serial_on |-> !mac_collision && !mac_carrier_sense)
		else $error("Serial mode forwarded collision or carrier");
	a_mii_crs_path: assert property (@(posedge ref_clk) disable iff (reset)
		(MODE_C == MODE_MII) |-> ##3 mac_carrier_sense == $past(phy_carrier_sense_in, 3))
		else $error("MII carrier sense not forwarded");
	a_gig_speed_low: assert property (@(posedge ref_clk) disable iff (reset)
		(MODE_C != MODE_MII) && link_is_gig |=> !low_speed_indicator)
		else $error("Speed indicator not low at 1G");
	a_rxclk_pulse_one: assert property (@(posedge ref_clk) disable iff (reset)
		rx_clk_rise |=> !rx_clk_rise)
		else $error("Receive clock edge pulse too long");
endmodule : mac_phy_interface_mapper
`default_nettype wire

/* src/phy_map_pkg.sv */
// Purpose: Shared constants and carrier types for the MAC-to-PHY interface mapper.
// Assumes: One 200 MHz clock; link clocks arrive as plain sampled inputs.
// Notes: Overview of the rules kept by the mapper follows.
// Overview of operation
// - Port meaning fixed by static mode only
// - MII: data on low nibble, upper low
// - GMII: enable, error, full byte
// - RGMII: enable rising ctl, enable XOR error falling ctl
// - RGMII: rising nibble low, falling high
// - RGMII receive nibbles and ctl split alike
// - MII receive uses low nibble only
// - Serial modes exchange full bytes
// - Serial modes: valid input means comma realign
// - MII collision and carrier sense used
// - Speed indicator high at 10/100
package phy_map_pkg;
	// Static interface modes
	typedef enum logic [2:0] {
		MODE_MII = 3'h0,
		MODE_GMII = 3'h1,
		MODE_RGMII = 3'h2,
		MODE_SGMII = 3'h3,
		MODE_BASEX = 3'h4
	} phy_mode_t;
	// Nibble field positions
	localparam int LO_NIB_LSB = 0;
	localparam int HI_NIB_LSB = 4;
	localparam int NIB_W = 4;
	localparam int BYTE_W = 8;
	localparam logic [3:0] NIB_ZERO = 4'h0;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	// Transmit side from the MAC core
	typedef struct packed {
		logic en;
		logic er;
		logic [7:0] data;
	} tx_word_t;
	// Receive side toward the MAC core
	typedef struct packed {
		logic dv;
		logic er;
		logic [7:0] data;
	} rx_word_t;
endpackage : phy_map_pkg
